// ---- dla_arbiter.sv ----
// memory sequencer arbiter with latency promotion and grant slices
// assumes requesters run on clk_in and pulse cmd while granted
// Summary of operation
// - host wait limit field, four clocks per code step, up to 60
// - host request waiting past its limit is promoted in priority
// - graphics wait limit in upper nibble of second latency register
// - graphics request waiting past its limit is promoted
// - pci wait limit in lower nibble of second latency register
// - pci request waiting past its limit is promoted
// - write queue slice in upper nibble of first slice register
// - host slice in lower nibble of first slice register, n+1 commands
// - graphics slice in upper nibble of second slice register
// - pci slice in lower nibble of second slice register
// - grant held until slice exceeded or request withdrawn
// - latency and slice registers are 8-bit read/write, reset to zero
// - write queue wait limit in upper nibble of first latency register
// - two-bit mode picks base priority order or round robin
module dla_arbiter (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [9:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [3:0] req_in,
  input wire logic [3:0] cmd_in,
  output logic [3:0] grant_out,
  output logic [3:0] promoted_out
);

  // ==========================================================================
  // registers
  logic [7:0] arb_mode_cfg;
  logic [7:0] write_queue_host_request_wait_limits;
  logic [7:0] graphics_pci_request_wait_limits;
  logic [7:0] write_queue_host_grant_slices;
  logic [7:0] graphics_pci_grant_slices;
  logic ack;
  logic [3:0] grant_q;
  logic [3:0] next_grant;
  logic [1:0] rr_pos;
  logic [1:0] next_rr_pos;
  logic [7:0] order;
  logic [3:0] exhausted;
  logic [3:0] promoted;
  logic [3:0] lat_code [dla_pkg::NUM_REQ];
  logic [3:0] slice_code [dla_pkg::NUM_REQ];

  // ==========================================================================
  // bus slave: one wait cycle, then the answer
  wire access = avs_read_in || avs_write_in;
  wire [7:0] reg_idx = avs_address_in[9:2];
  wire wr_take = avs_write_in && ack && avs_byteenable_in[0];
  wire [7:0] wr_byte = avs_writedata_in[7:0];
  wire sel_mode = reg_idx == dla_pkg::IDX_ARB_MODE;
  wire sel_lat1 = reg_idx == dla_pkg::IDX_WQ_HOST_LAT;
  wire sel_lat2 = reg_idx == dla_pkg::IDX_GFX_PCI_LAT;
  wire sel_slc1 = reg_idx == dla_pkg::IDX_WQ_HOST_SLICE;
  wire sel_slc2 = reg_idx == dla_pkg::IDX_GFX_PCI_SLICE;
  wire sel_stat = reg_idx == dla_pkg::IDX_STATUS;
  wire [1:0] arb_mode = arb_mode_cfg[dla_pkg::MODE_MSB:dla_pkg::MODE_LSB];
  // only the mode field is kept, other bits read as zero
  wire [7:0] mode_view = {2'h0, arb_mode, 4'h0};
  wire [7:0] mode_wr =
    {2'h0, wr_byte[dla_pkg::MODE_MSB:dla_pkg::MODE_LSB], 4'h0};
  wire [7:0] rd_mux =
    sel_mode ? mode_view :
    sel_lat1 ? write_queue_host_request_wait_limits :
    sel_lat2 ? graphics_pci_request_wait_limits :
    sel_slc1 ? write_queue_host_grant_slices :
    sel_slc2 ? graphics_pci_grant_slices :
    sel_stat ? {promoted, grant_q} : dla_pkg::REG_RESET;

  assign avs_waitrequest_out = access && !ack;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack <= 1'b0;
    end else begin
      ack <= access && !ack;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      avs_readdata_out <= '0;
    end else if (avs_read_in && !ack) begin
      avs_readdata_out <= dla_pkg::BUS_W'(rd_mux);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      arb_mode_cfg <= dla_pkg::REG_RESET;
      write_queue_host_request_wait_limits <= dla_pkg::REG_RESET;
      graphics_pci_request_wait_limits <= dla_pkg::REG_RESET;
      write_queue_host_grant_slices <= dla_pkg::REG_RESET;
      graphics_pci_grant_slices <= dla_pkg::REG_RESET;
    end else if (wr_take) begin
      if (sel_mode) arb_mode_cfg <= mode_wr;
      if (sel_lat1) write_queue_host_request_wait_limits <= wr_byte;
      if (sel_lat2) graphics_pci_request_wait_limits <= wr_byte;
      if (sel_slc1) write_queue_host_grant_slices <= wr_byte;
      if (sel_slc2) graphics_pci_grant_slices <= wr_byte;
    end
  end

  // ==========================================================================
  // field routing to the requester trackers
  assign lat_code[dla_pkg::REQ_HOST] = write_queue_host_request_wait_limits
    [dla_pkg::LO_MSB:dla_pkg::LO_LSB];
  assign lat_code[dla_pkg::REQ_WQ] = write_queue_host_request_wait_limits
    [dla_pkg::HI_MSB:dla_pkg::HI_LSB];
  assign lat_code[dla_pkg::REQ_GFX] = graphics_pci_request_wait_limits
    [dla_pkg::HI_MSB:dla_pkg::HI_LSB];
  assign lat_code[dla_pkg::REQ_PCI] = graphics_pci_request_wait_limits
    [dla_pkg::LO_MSB:dla_pkg::LO_LSB];
  assign slice_code[dla_pkg::REQ_WQ] = write_queue_host_grant_slices
    [dla_pkg::HI_MSB:dla_pkg::HI_LSB];
  assign slice_code[dla_pkg::REQ_HOST] = write_queue_host_grant_slices
    [dla_pkg::LO_MSB:dla_pkg::LO_LSB];
  assign slice_code[dla_pkg::REQ_GFX] = graphics_pci_grant_slices
    [dla_pkg::HI_MSB:dla_pkg::HI_LSB];
  assign slice_code[dla_pkg::REQ_PCI] = graphics_pci_grant_slices
    [dla_pkg::LO_MSB:dla_pkg::LO_LSB];

  genvar gi;
  generate
    for (gi = 0; gi < dla_pkg::NUM_REQ; gi++) begin : g_track
      dla_req_track u_track (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .req_in(req_in[gi]),
        .granted_in(grant_q[gi]),
        .cmd_in(cmd_in[gi]),
        .lat_code_in(lat_code[gi]),
        .slice_code_in(slice_code[gi]),
        .promoted_out(promoted[gi]),
        .exhausted_out(exhausted[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // priority order
  function automatic logic [2:0] pick(input logic [3:0] mask,
                                      input logic [7:0] ord);
    logic [2:0] res;
    res = 3'h0;
    for (int k = dla_pkg::NUM_REQ - 1; k >= 0; k--) begin
      if (mask[ord[k*2 +: 2]]) begin
        res = {1'b1, 2'(k)};
      end
    end
    return res;
  endfunction : pick

  always_comb begin
    order = dla_pkg::ORDER_GFX_FIRST;
    case (arb_mode)
      dla_pkg::MODE_GFX_FIRST: order = dla_pkg::ORDER_GFX_FIRST;
      dla_pkg::MODE_HOST_FIRST: order = dla_pkg::ORDER_HOST_FIRST;
      dla_pkg::MODE_PCI_BEFORE_GFX: order = dla_pkg::ORDER_PCI_BEFORE_GFX;
      dla_pkg::MODE_ROUND_ROBIN: begin
        // start one place after the last winner in the base order
        for (int k = 0; k < dla_pkg::NUM_REQ; k++) begin
          order[k*2 +: 2] =
            dla_pkg::ORDER_GFX_FIRST[2'(rr_pos + 2'(k + 1))*2 +: 2];
        end
      end
      default: order = dla_pkg::ORDER_GFX_FIRST;
    endcase
  end

  // ==========================================================================
  // grant selection: promoted requests first, then the order of the current mode
  wire [2:0] pick_prom = pick(req_in & promoted, order);
  wire [2:0] pick_base = pick(req_in, order);
  wire [2:0] pick_win = pick_prom[2] ? pick_prom : pick_base;
  wire [1:0] win_idx = order[pick_win[1:0]*2 +: 2];
  wire holding = |(grant_q & req_in & ~exhausted);

  always_comb begin
    next_grant = 4'h0;
    next_rr_pos = rr_pos;
    if (|grant_q) begin
      // one idle cycle after a release lets counters restart
      next_grant = holding ? grant_q : 4'h0;
    end else if (pick_win[2]) begin
      next_grant = 4'(4'h1 << win_idx);
      if (arb_mode == dla_pkg::MODE_ROUND_ROBIN) begin
        next_rr_pos = 2'(rr_pos + 2'h1 + pick_win[1:0]);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      grant_q <= 4'h0;
      rr_pos <= 2'h3;
    end else begin
      grant_q <= next_grant;
      rr_pos <= next_rr_pos;
    end
  end

  assign grant_out = grant_q;
  assign promoted_out = promoted;

  // ==========================================================================
  // checks
  chk_grant_onehot: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $onehot0(grant_q)) else $error("more than one grant");

  chk_grant_hold: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (|grant_q) && holding |=> grant_q == $past(grant_q))
    else $error("grant moved while holder kept its slice");

  chk_grant_release: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (|(grant_q & exhausted)) || ((|grant_q) && !(|(grant_q & req_in)))
    |=> grant_q == 4'h0) else $error("grant not released");

  chk_regs_reset: assert property (
    @(posedge clk_in)
    rst_in |=> write_queue_host_request_wait_limits == dla_pkg::REG_RESET &&
    graphics_pci_request_wait_limits == dla_pkg::REG_RESET &&
    write_queue_host_grant_slices == dla_pkg::REG_RESET &&
    graphics_pci_grant_slices == dla_pkg::REG_RESET)
    else $error("register not cleared by reset");

  chk_bus_answer: assert property (
    @(posedge clk_in) disable iff (rst_in)
    avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer late");

  chk_write_lands: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_take && sel_lat2 |=>
    graphics_pci_request_wait_limits == $past(wr_byte))
    else $error("latency write lost");

  chk_host_promote: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $rose(promoted[dla_pkg::REQ_HOST]) |->
    $past(req_in[dla_pkg::REQ_HOST] && !grant_q[dla_pkg::REQ_HOST], 1) &&
    $past(req_in[dla_pkg::REQ_HOST], 2) == 1'b1 ||
    lat_code[dla_pkg::REQ_HOST] == 4'h0)
    else $error("host promoted without waiting");

  chk_promote_clear: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (grant_q & promoted) == 4'h0)
    else $error("granted requester still promoted");

  chk_promote_wins: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !(|grant_q) && (|(req_in & promoted)) |=>
    (|(grant_q & $past(promoted))))
    else $error("promoted request lost arbitration");

  chk_host_first: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !(|grant_q) && arb_mode == dla_pkg::MODE_HOST_FIRST &&
    req_in[dla_pkg::REQ_HOST] && !(|(req_in & promoted)) |=>
    grant_q[dla_pkg::REQ_HOST])
    else $error("host first mode order broken");

  chk_mode_write: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_take && sel_mode |=>
    arb_mode == $past(wr_byte[dla_pkg::MODE_MSB:dla_pkg::MODE_LSB]))
    else $error("mode write lost");

  chk_slice_write: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_take && sel_slc1 |=> write_queue_host_grant_slices == $past(wr_byte))
    else $error("slice write lost");

  chk_idle_grant: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !(|grant_q) && (|req_in) |=> $onehot(grant_q))
    else $error("idle arbiter ignored a request");

  chk_grant_to_req: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (|grant_q) && grant_q != $past(grant_q) |->
    (|(grant_q & $past(req_in))))
    else $error("grant given to a requester that did not ask");

  chk_read_upper: assert property (
    @(posedge clk_in) disable iff (rst_in)
    avs_readdata_out[dla_pkg::BUS_W-1:dla_pkg::REG_W] == '0)
    else $error("read data upper bytes not zero");

endmodule : dla_arbiter

// ---- dla_pkg.sv ----
// constants shared by the memory request arbiter and its requester tracker
// assumes one 20 MHz clock and a synchronous active-high reset
package dla_pkg;

  // ==========================================================================
  // clock
  localparam int CLK_HZ = 20_000_000;

  // ==========================================================================
  // requesters
  localparam int NUM_REQ = 4;
  localparam logic [1:0] REQ_HOST = 2'h0;
  localparam logic [1:0] REQ_GFX = 2'h1;
  localparam logic [1:0] REQ_PCI = 2'h2;
  localparam logic [1:0] REQ_WQ = 2'h3;

  // ==========================================================================
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_ARB_MODE = 8'h4B;
  localparam logic [7:0] IDX_WQ_HOST_LAT = 8'h4C;
  localparam logic [7:0] IDX_GFX_PCI_LAT = 8'h4D;
  localparam logic [7:0] IDX_WQ_HOST_SLICE = 8'h4E;
  localparam logic [7:0] IDX_GFX_PCI_SLICE = 8'h4F;
  localparam logic [7:0] IDX_STATUS = 8'h40;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int REG_W = 8;
  localparam int BUS_W = 32;

  // ==========================================================================
  // field positions
  localparam int LO_MSB = 3;
  localparam int LO_LSB = 0;
  localparam int HI_MSB = 7;
  localparam int HI_LSB = 4;
  localparam int MODE_MSB = 5;
  localparam int MODE_LSB = 4;

  // ==========================================================================
  // timing: one latency code step is four clocks
  localparam int LAT_STEP_CLKS = 4;
  localparam int WAIT_CNT_W = 6;
  localparam logic [WAIT_CNT_W-1:0] WAIT_CNT_MAX = 6'h3F;
  localparam int CMD_CNT_W = 5;

  // ==========================================================================
  // base priority modes and orders, first entry in bits 1:0
  localparam logic [1:0] MODE_GFX_FIRST = 2'h0;
  localparam logic [1:0] MODE_HOST_FIRST = 2'h1;
  localparam logic [1:0] MODE_PCI_BEFORE_GFX = 2'h2;
  localparam logic [1:0] MODE_ROUND_ROBIN = 2'h3;
  localparam logic [7:0] ORDER_GFX_FIRST = 8'hE1;
  localparam logic [7:0] ORDER_HOST_FIRST = 8'hE4;
  localparam logic [7:0] ORDER_PCI_BEFORE_GFX = 8'hD8;

endpackage : dla_pkg

// ---- dla_req_agents.sv ----
// requester agent model on the memory side of the arbiter
// assumes the bench drives want and command enables on clock edges
module dla_req_agents (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] want_in,
  input wire logic [3:0] cmd_en_in,
  input wire logic [3:0] grant_in,
  output logic [3:0] req_out,
  output logic [3:0] cmd_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // requests and command pulses
  // a request stays up until withdrawn; commands only follow a seen grant,
  // so one stray pulse lands in the idle cycle after the grant ends
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      req_out <= 4'h0;
      cmd_out <= 4'h0;
    end else begin
      req_out <= want_in;
      cmd_out <= want_in & cmd_en_in & grant_in;
    end
  end
endmodule : dla_req_agents

// ---- dla_req_track.sv ----
// per-requester wait timer and grant slice counter
// assumes request and command strobes come from logic on the same clock
module dla_req_track (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic granted_in,
  input wire logic cmd_in,
  input wire logic [3:0] lat_code_in,
  input wire logic [3:0] slice_code_in,
  output logic promoted_out,
  output logic exhausted_out
);

  // ==========================================================================
  // wait timer
  logic [dla_pkg::WAIT_CNT_W-1:0] wait_cnt;
  logic [dla_pkg::CMD_CNT_W-1:0] cmd_cnt;
  wire [dla_pkg::WAIT_CNT_W-1:0] wait_limit =
    dla_pkg::WAIT_CNT_W'(lat_code_in) *
    dla_pkg::WAIT_CNT_W'(dla_pkg::LAT_STEP_CLKS);

  always_ff @(posedge clk_in) begin
    if (rst_in || !req_in || granted_in) begin
      wait_cnt <= '0;
    end else if (wait_cnt != dla_pkg::WAIT_CNT_MAX) begin
      wait_cnt <= wait_cnt + 1'b1;
    end
  end

  // promoted only while still waiting, so a grant clears it at once
  assign promoted_out = req_in && !granted_in &&
    (wait_cnt > wait_limit);

  // ==========================================================================
  // slice counter: code n allows n plus one commands
  always_ff @(posedge clk_in) begin
    if (rst_in || !granted_in) begin
      cmd_cnt <= '0;
    end else if (cmd_in && !exhausted_out) begin
      cmd_cnt <= cmd_cnt + 1'b1;
    end
  end

  assign exhausted_out = cmd_cnt >
    dla_pkg::CMD_CNT_W'(slice_code_in);

endmodule : dla_req_track

// ---- tb_dla_arbiter.sv ----
// self-checking bench for the memory request arbiter
// assumes the requester agent model and a 20 MHz clock
module tb_dla_arbiter;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic [3:0] be;
    logic [7:0] exp;
  } dla_row_s;
  // ==========================================================================
  // tables
  localparam dla_row_s ROWS [8] = '{'{10'h130, 8'hA5, 4'h1, 8'hA5},
    '{10'h134, 8'h5A, 4'h1, 8'h5A}, '{10'h138, 8'hC3, 4'hF, 8'hC3},
    '{10'h13C, 8'h3C, 4'h1, 8'h3C}, '{10'h13C, 8'hFF, 4'hE, 8'h3C},
    '{10'h12E, 8'hFF, 4'h1, 8'h30}, '{10'h3FC, 8'hFF, 4'h1, 8'h00},
    '{10'h131, 8'h00, 4'h1, 8'h00}};
  localparam logic [9:0] CFG_A [5] = '{10'h12C, 10'h130, 10'h134, 10'h138,
    10'h13C};
  localparam logic [7:0] CFG_D [5] = '{8'h00, 8'h21, 8'h30, 8'hF0, 8'h37};
  localparam logic [3:0] LAT [4] = '{4'h1, 4'h3, 4'h0, 4'h2};
  localparam logic [3:0] SLC [4] = '{4'h0, 4'h3, 4'h7, 4'hF};
  localparam logic [3:0] FIRST [4] = '{4'h2, 4'h1, 4'h1, 4'h2};
  localparam logic [3:0] SECOND [4] = '{4'h1, 4'h2, 4'h4, 4'h1};
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] want = 4'h0;
  logic [3:0] cmd_en = 4'h0;
  logic [3:0] req;
  logic [3:0] cmd;
  logic [3:0] grant;
  logic [3:0] promoted;
  logic [31:0] q;
  int miscompares = 0;
  int checks_done = 0;
  int n;
  int c;
  always #25 clk_in = ~clk_in;
  dla_arbiter dla_arbiter_i (.clk_in(clk_in), .rst_in(rst_in),
    .avs_address_in(avs_address), .avs_read_in(avs_read),
    .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
    .avs_byteenable_in(avs_byteenable), .avs_readdata_out(avs_readdata),
    .avs_waitrequest_out(avs_waitrequest), .req_in(req), .cmd_in(cmd),
    .grant_out(grant), .promoted_out(promoted));
  dla_req_agents dla_req_agents_i (.clk_in(clk_in), .rst_in(rst_in),
    .want_in(want), .cmd_en_in(cmd_en), .grant_in(grant), .req_out(req),
    .cmd_out(cmd));
  // ==========================================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask : tick
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [9:0] a,
      input logic [7:0] d, input logic [3:0] be);
    int k;
    k = 0;
    @(posedge clk_in);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    #1;
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      tick();
      k++;
    end
    if (k == 50) miscompares++;
    // answer stands now and is copied to q here, before the coming edge
    q = avs_readdata;
    @(posedge clk_in);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wait_grant(input logic [3:0] g);
    int k;
    k = 0;
    while (grant !== g && k < 200) begin
      tick();
      k++;
    end
    check({28'h0, grant}, {28'h0, g});
  endtask : wait_grant
  initial begin
    #1_000_000;
    miscompares++;
    stop_test();
  end
  // ==========================================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, CFG_A[i], 8'h00, 4'h0);
      check(q, 32'h0);
    end
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, ROWS[i].addr, ROWS[i].wdata, ROWS[i].be);
      bus(1'b0, ROWS[i].addr, 8'h00, 4'h0);
      check(q, {24'h0, ROWS[i].exp});
    end
    for (int i = 0; i < 5; i++) bus(1'b1, CFG_A[i], CFG_D[i], 4'h1);
    // grant length per slice code, then one idle cycle and a new grant
    for (int r = 0; r < 4; r++) begin
      @(posedge clk_in);
      want <= 4'h1 << r;
      cmd_en <= 4'hF;
      wait_grant(4'h1 << r);
      n = 0;
      while (grant[r] === 1'b1 && n < 40) begin
        n++;
        tick();
      end
      check(n, SLC[r] + 3);
      tick();
      check({28'h0, grant}, {28'h0, 4'h1 << r});
      @(posedge clk_in);
      want <= 4'h0;
      cmd_en <= 4'h0;
      wait_grant(4'h0);
    end
    // waiting past the limit promotes, the promoted one beats base order
    for (int r = 0; r < 4; r++) begin
      @(posedge clk_in);
      want <= 4'h1 << ((r + 1) % 4);
      wait_grant(4'h1 << ((r + 1) % 4));
      @(posedge clk_in);
      want <= want | (4'h1 << r);
      tick();
      n = 0;
      while (promoted[r] !== 1'b1 && n < 300) begin
        n++;
        tick();
      end
      check(n, 4 * LAT[r] + 1);
      bus(1'b0, 10'h100, 8'h00, 4'h0);
      check(q, {24'h0, 4'h1 << r, 4'h1 << ((r + 1) % 4)});
      c = (r < 2) ? 0 : 1;
      @(posedge clk_in);
      want <= (4'h1 << r) | (4'h1 << c);
      wait_grant(4'h1 << r);
      check({31'h0, promoted[r]}, 32'h0);
      @(posedge clk_in);
      want <= 4'h0;
      wait_grant(4'h0);
    end
    // base order for every mode, winner withdraws before its slice ends
    bus(1'b1, 10'h130, 8'hFF, 4'h1);
    bus(1'b1, 10'h134, 8'hFF, 4'h1);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 10'h12C, {2'h0, m[1:0], 4'h0}, 4'h1);
      @(posedge clk_in);
      want <= 4'hF;
      wait_grant(FIRST[m]);
      @(posedge clk_in);
      want <= 4'hF & ~FIRST[m];
      wait_grant(SECOND[m]);
      @(posedge clk_in);
      want <= 4'h0;
      wait_grant(4'h0);
    end
    // mid-run reset drops the grant and clears every register
    @(posedge clk_in);
    want <= 4'h4;
    wait_grant(4'h4);
    @(posedge clk_in);
    rst_in <= 1'b1;
    want <= 4'h0;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    tick();
    check({28'h0, grant}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, CFG_A[i], 8'h00, 4'h0);
      check(q, 32'h0);
    end
    stop_test();
  end
endmodule : tb_dla_arbiter
